// ==== rtl/ddr3_pwr_pkg.sv ====
// Constants, state codes and pin bundle for the DDR3 power-state block
package ddr3_pwr_pkg;

  // Clock
  localparam int TCK_NS = 40;

  // Timing figures and derived cycle counts (least times round up)
  localparam int T_XS_NS = 170;
  localparam int XS_CYC = (T_XS_NS + TCK_NS - 1) / TCK_NS;
  localparam int T_XP_NS = 24;
  localparam int XP_CYC = (T_XP_NS + TCK_NS - 1) / TCK_NS;
  localparam int XSDLL_CYC = 512;
  localparam int MOD_CYC = 12;
  localparam int CKE_MIN_CYC = 3;
  localparam int T_SREF_NS = 7800;
  localparam int SREF_CYC = (T_SREF_NS / TCK_NS < 1) ? 1 : T_SREF_NS / TCK_NS;

  // Burst lengths in clocks
  localparam logic [2:0] BL8_CLK = 3'h4;
  localparam logic [2:0] BC4_CLK = 3'h2;

  // Latency bases and DLL-off fixed latencies
  localparam logic [4:0] CL_BASE = 5'h04;
  localparam logic [4:0] CWL_BASE = 5'h05;
  localparam logic [4:0] DLL_OFF_CL = 5'h06;
  localparam logic [4:0] DLL_OFF_CWL = 5'h06;

  // Mode register field positions
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_CL_LSB = 4;
  localparam int MR1_DLL_BIT = 0;
  localparam int MR1_AL_LSB = 3;
  localparam int MR2_CWL_LSB = 3;
  localparam int ADDR_AP_BIT = 10;
  localparam int ADDR_OTF_BIT = 12;

  // Mode register reset values
  localparam logic [15:0] MR_RESET = 16'h0000;

  // Software register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MR0 = 4'h4;
  localparam logic [3:0] REG_MR1 = 4'h5;
  localparam logic [3:0] REG_MR2 = 4'h6;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam int CTRL_SREF_EN_BIT = 0;
  localparam int CTRL_CLR_ILL_BIT = 1;

  // Command codes on RAS, CAS, WE (CS low)
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  // Power states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ACT  = 5'b00010,
    ST_PPD  = 5'b00100,
    ST_APD  = 5'b01000,
    ST_SREF = 5'b10000
  } pwr_state_type;

  // Command and control pins
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        odt;
    logic [2:0]  ba;
    logic [15:0] addr;
  } pin_type;

endpackage

// ==== rtl/ddr3_lat_pipe.sv ====
// Latency shift pipe: one pulse out a programmed number of cycles after each fire
module ddr3_lat_pipe
  import ddr3_pwr_pkg::*;
#(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Request
  input  wire logic       i_fire,
  input  wire logic [4:0] i_delay,
  // Result
  output logic            o_hit
);

  initial begin
    if (DEPTH < 2 || DEPTH > 32) $error("DEPTH must be 2..32");
  end

  logic [DEPTH-1:0] pipe_reg;
  logic [DEPTH-1:0] pipe_next;
  logic [DEPTH-1:0] mark;

  assign mark = i_fire ? (DEPTH'(1) << (i_delay - 5'h01)) : '0;
  assign pipe_next = (pipe_reg >> 1) | mark;
  assign o_hit = pipe_reg[0];

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pipe_reg <= '0;
    end else begin
      pipe_reg <= pipe_next;
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_fire_delay_ok: assert property (i_fire |-> i_delay != 5'h00)
    else $error("latency of zero requested");

endmodule

// ==== rtl/ddr3_pwr_ctrl.sv ====
// Device-side command decode, clock-enable power states and DLL-off latency
module ddr3_pwr_ctrl
  import ddr3_pwr_pkg::*;
#(
  parameter int NUM_BANKS = 8
) (
  // Clock and resets
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_reset_n,
  // Memory pins
  input  wire pin_type     i_pins,
  // Software port
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [31:0]      o_reg_rdata,
  // Device status
  output pwr_state_type    o_power_state,
  output logic             o_idle,
  output logic             o_dll_off,
  output logic             o_burst_busy,
  output logic             o_rd_start,
  output logic             o_wr_start,
  output logic             o_odt_en,
  output logic             o_self_refresh,
  output logic             o_illegal
);

  initial begin
    if (NUM_BANKS != 8) $error("NUM_BANKS must be 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset and pin synchronisers
  logic rst_any;
  assign rst_any = i_rst | ~i_reset_n;

  pin_type pin_meta_reg;
  pin_type pin_reg;
  logic cke_prev_reg;

  always_ff @(posedge i_sys_clk or posedge rst_any) begin
    if (rst_any) begin
      pin_meta_reg <= '0;
      pin_reg <= '0;
      cke_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= i_pins;
      pin_reg <= pin_meta_reg;
      cke_prev_reg <= pin_reg.cke;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic [2:0] cmd;
  logic nop_des, cke_hh, cke_hl, cke_lh;
  logic is_mrs, is_ref, is_pre, is_act, is_wr, is_rd;
  assign cmd = {pin_reg.ras_n, pin_reg.cas_n, pin_reg.we_n};
  assign nop_des = pin_reg.cs_n | (cmd == CMD_NOP);
  assign cke_hh = cke_prev_reg & pin_reg.cke;
  assign cke_hl = cke_prev_reg & ~pin_reg.cke;
  assign cke_lh = ~cke_prev_reg & pin_reg.cke;
  assign is_mrs = cke_hh & ~pin_reg.cs_n & (cmd == CMD_MRS);
  assign is_ref = ~pin_reg.cs_n & (cmd == CMD_REF);
  assign is_pre = cke_hh & ~pin_reg.cs_n & (cmd == CMD_PRE);
  assign is_act = cke_hh & ~pin_reg.cs_n & (cmd == CMD_ACT);
  assign is_wr = cke_hh & ~pin_reg.cs_n & (cmd == CMD_WR);
  assign is_rd = cke_hh & ~pin_reg.cs_n & (cmd == CMD_RD);

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers and latencies
  logic [15:0] mr0_reg, mr1_reg, mr2_reg;
  logic dll_off_reg;
  logic [4:0] cl_val, cwl_val, al_val, rd_lat, wr_lat;
  logic [1:0] al_sel;

  always_ff @(posedge i_sys_clk or posedge rst_any) begin
    if (rst_any) begin
      mr0_reg <= MR_RESET;
      mr1_reg <= MR_RESET;
      mr2_reg <= MR_RESET;
      dll_off_reg <= 1'b0;
    end else begin
      if (is_mrs && pin_reg.ba == 3'h0) mr0_reg <= pin_reg.addr;
      if (is_mrs && pin_reg.ba == 3'h1) begin
        mr1_reg <= pin_reg.addr;
        dll_off_reg <= pin_reg.addr[MR1_DLL_BIT];
      end
      if (is_mrs && pin_reg.ba == 3'h2) mr2_reg <= pin_reg.addr;
    end
  end

  assign cl_val = dll_off_reg ? DLL_OFF_CL : CL_BASE + {2'h0, mr0_reg[MR0_CL_LSB+:3]};
  assign cwl_val = dll_off_reg ? DLL_OFF_CWL : CWL_BASE + {2'h0, mr2_reg[MR2_CWL_LSB+:3]};
  assign al_sel = mr1_reg[MR1_AL_LSB+:2];
  assign al_val = (al_sel == 2'h1) ? cl_val - 5'h01 : (al_sel == 2'h2) ? cl_val - 5'h02 : 5'h00;
  assign rd_lat = al_val + cl_val - {4'h0, dll_off_reg};
  assign wr_lat = al_val + cwl_val;

  ////////////////////////////////////////////////////////////////////////////
  // Bursts and banks
  logic [2:0] burst_cnt_reg, burst_cnt_next, burst_len;
  logic burst_go, burst_busy, ap_reg, burst_last, bl8, busy_out_reg;
  logic [2:0] ap_bank_reg;
  logic [NUM_BANKS-1:0] bank_open_reg, bank_open_next, ap_mask;

  assign burst_busy = burst_cnt_reg != 3'h0;
  assign burst_last = burst_cnt_reg == 3'h1;
  assign burst_go = (is_rd | is_wr) & ~burst_busy;
  assign bl8 = (mr0_reg[MR0_BL_LSB+:2] == 2'h0) |
    ((mr0_reg[MR0_BL_LSB+:2] == 2'h1) & pin_reg.addr[ADDR_OTF_BIT]);
  assign burst_len = bl8 ? BL8_CLK : BC4_CLK;
  assign burst_cnt_next = burst_go ? burst_len : burst_busy ? burst_cnt_reg - 3'h1 : 3'h0;
  assign ap_mask = (ap_reg & burst_busy) ? (NUM_BANKS'(1) << ap_bank_reg) : '0;

  generate
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic hit;
      assign hit = pin_reg.ba == 3'(b);
      assign bank_open_next[b] = (is_act & hit) ? 1'b1 :
        ((is_pre & (hit | pin_reg.addr[ADDR_AP_BIT])) | (ap_mask[b] & burst_last)) ? 1'b0 :
        bank_open_reg[b];
    end
  endgenerate

  always_ff @(posedge i_sys_clk or posedge rst_any) begin
    if (rst_any) begin
      burst_cnt_reg <= 3'h0;
      ap_reg <= 1'b0;
      ap_bank_reg <= 3'h0;
      busy_out_reg <= 1'b0;
      bank_open_reg <= '0;
    end else begin
      burst_cnt_reg <= burst_cnt_next;
      busy_out_reg <= burst_cnt_next != 3'h0;
      bank_open_reg <= bank_open_next;
      if (burst_go) begin
        ap_reg <= pin_reg.addr[ADDR_AP_BIT];
        ap_bank_reg <= pin_reg.ba;
      end
    end
  end

  ddr3_lat_pipe #(.DEPTH(32)) u_rd_pipe (
    .i_sys_clk(i_sys_clk),
    .i_rst(rst_any),
    .i_fire(burst_go & is_rd),
    .i_delay(rd_lat),
    .o_hit(o_rd_start)
  );

  ddr3_lat_pipe #(.DEPTH(32)) u_wr_pipe (
    .i_sys_clk(i_sys_clk),
    .i_rst(rst_any),
    .i_fire(burst_go & is_wr),
    .i_delay(wr_lat),
    .o_hit(o_wr_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Exit delay timers and CKE pulse tracking
  logic [9:0] xsdll_cnt_reg;
  logic [7:0] xs_cnt_reg, xp_cnt_reg, mod_cnt_reg, cke_cnt_reg;
  logic timers_done, pd_any;
  pwr_state_type state_reg, state_next;

  assign pd_any = (state_reg == ST_PPD) | (state_reg == ST_APD);
  assign timers_done = (xs_cnt_reg == 8'h00) & (xp_cnt_reg == 8'h00) &
    (mod_cnt_reg == 8'h00) & (xsdll_cnt_reg == 10'h000);

  always_ff @(posedge i_sys_clk or posedge rst_any) begin
    if (rst_any) begin
      xs_cnt_reg <= 8'h00;
      xsdll_cnt_reg <= 10'h000;
      xp_cnt_reg <= 8'h00;
      mod_cnt_reg <= 8'h00;
      cke_cnt_reg <= 8'hff; // Saturated: the first CKE rise after reset is no short pulse
    end else begin
      xs_cnt_reg <= (state_reg == ST_SREF && state_next != ST_SREF) ? 8'(XS_CYC) :
        (xs_cnt_reg != 8'h00) ? xs_cnt_reg - 8'h01 : 8'h00;
      xsdll_cnt_reg <= (state_reg == ST_SREF && state_next != ST_SREF) ? 10'(XSDLL_CYC) :
        (xsdll_cnt_reg != 10'h000) ? xsdll_cnt_reg - 10'h001 : 10'h000;
      xp_cnt_reg <= (pd_any && !(state_next inside {ST_PPD, ST_APD})) ? 8'(XP_CYC) :
        (xp_cnt_reg != 8'h00) ? xp_cnt_reg - 8'h01 : 8'h00;
      mod_cnt_reg <= is_mrs ? 8'(MOD_CYC) :
        (mod_cnt_reg != 8'h00) ? mod_cnt_reg - 8'h01 : 8'h00;
      cke_cnt_reg <= (cke_hl | cke_lh) ? 8'h01 :
        (cke_cnt_reg != 8'hff) ? cke_cnt_reg + 8'h01 : cke_cnt_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine
  logic idle_now, any_open, pd_active_type, illegal_ev;
  assign any_open = |(bank_open_next & ~ap_mask);
  // CKE high before the edge: entry into self-refresh sees CKE already low
  assign idle_now = ~(|bank_open_reg) & ~burst_busy & cke_prev_reg & timers_done;
  assign pd_active_type = any_open;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE, ST_ACT: begin
        if (cke_hl && nop_des) begin
          state_next = pd_active_type ? ST_APD : ST_PPD;
        end else if (cke_hl && is_ref && idle_now) begin
          state_next = ST_SREF;
        end else if (cke_hh) begin
          state_next = (|bank_open_next) ? ST_ACT : ST_IDLE;
        end
      end
      ST_PPD, ST_APD: begin
        if (cke_lh && nop_des) state_next = (|bank_open_reg) ? ST_ACT : ST_IDLE;
      end
      ST_SREF: begin
        if (pin_reg.cke) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Protocol violations by the controller are flagged; short CKE pulses and commands inside the exit timers other than self-refresh entry are still obeyed
  assign illegal_ev =
    ((cke_hl | cke_lh) & (cke_cnt_reg < 8'(CKE_MIN_CYC))) |
    ((state_reg inside {ST_IDLE, ST_ACT}) & cke_hl & ~nop_des & ~is_ref) |
    ((state_reg inside {ST_IDLE, ST_ACT}) & cke_hl & is_ref & ~idle_now) |
    (pd_any & cke_lh & ~nop_des) |
    ((xs_cnt_reg != 8'h00) & ~nop_des) |
    ((xsdll_cnt_reg != 10'h000) & (is_rd | pin_reg.odt)) |
    ((is_rd | is_wr) & burst_busy) |
    ((xsdll_cnt_reg != 10'h000) & (mod_cnt_reg != 8'h00) & cke_hl);

  ////////////////////////////////////////////////////////////////////////////
  // Self-refresh refresh timer and software registers
  logic [7:0] ctrl_reg;
  logic [15:0] sref_cnt_reg;
  logic illegal_reg, sref_tick, clr_ill, ctrl_wr;
  logic [31:0] status_word, rd_mux;

  assign sref_tick = (state_reg == ST_SREF) & ctrl_reg[CTRL_SREF_EN_BIT] &
    (sref_cnt_reg == 16'(SREF_CYC - 1));
  assign ctrl_wr = i_reg_wr & (i_reg_addr == REG_CTRL);
  assign clr_ill = ctrl_wr & i_reg_wdata[CTRL_CLR_ILL_BIT];
  assign status_word = {8'h00, bank_open_reg, 7'h00, burst_busy, illegal_reg, o_idle,
    dll_off_reg, state_reg};
  assign rd_mux = (i_reg_addr == REG_CTRL) ? {24'h0, ctrl_reg} :
    (i_reg_addr == REG_STATUS) ? status_word :
    (i_reg_addr == REG_MR0) ? {16'h0, mr0_reg} :
    (i_reg_addr == REG_MR1) ? {16'h0, mr1_reg} :
    (i_reg_addr == REG_MR2) ? {16'h0, mr2_reg} : 32'h0;

  always_ff @(posedge i_sys_clk or posedge rst_any) begin
    if (rst_any) begin
      state_reg <= ST_IDLE;
      ctrl_reg <= CTRL_RESET;
      sref_cnt_reg <= 16'h0000;
      illegal_reg <= 1'b0;
      o_reg_rdata <= 32'h0;
      o_self_refresh <= 1'b0;
      o_odt_en <= 1'b0;
      o_idle <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (ctrl_wr) ctrl_reg <= {7'h00, i_reg_wdata[CTRL_SREF_EN_BIT]};
      sref_cnt_reg <= (state_reg != ST_SREF || sref_tick) ? 16'h0000 : sref_cnt_reg + 16'h0001;
      illegal_reg <= illegal_ev | (illegal_reg & ~clr_ill);
      o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0;
      o_self_refresh <= sref_tick;
      o_odt_en <= pin_reg.odt & (state_next != ST_SREF);
      o_idle <= idle_now & (state_next == ST_IDLE);
    end
  end

  assign o_power_state = state_reg;
  assign o_dll_off = dll_off_reg;
  assign o_burst_busy = busy_out_reg;
  assign o_illegal = illegal_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (rst_any);

  a_pd_entry_type: assert property ((state_reg inside {ST_IDLE, ST_ACT}) && cke_hl && nop_des
    |=> (state_reg == ST_APD) == $past(pd_active_type))
    else $error("wrong power-down type");
  a_sref_entry: assert property (state_reg == ST_IDLE && cke_hl && is_ref && idle_now
    |=> state_reg == ST_SREF)
    else $error("self-refresh not entered");
  a_sref_exit_cke: assert property (state_reg == ST_SREF && pin_reg.cke
    |=> state_reg == ST_IDLE ##0 xs_cnt_reg == 8'(XS_CYC))
    else $error("self-refresh exit missed");
  a_pd_holds_low: assert property (pd_any && !pin_reg.cke |=> state_reg == $past(state_reg))
    else $error("power-down left with CKE low");
  a_nop_keeps_burst: assert property (burst_busy && nop_des
    |=> burst_cnt_reg == $past(burst_cnt_reg) - 3'h1)
    else $error("burst disturbed by NOP");
  a_bl8_full_run: assert property (burst_go && bl8 |=> burst_busy [*4])
    else $error("BL8 burst cut short");
  a_no_refresh_pd: assert property (pd_any |=> !o_self_refresh)
    else $error("refresh in power-down");
  a_odt_off_sref: assert property (state_reg == ST_SREF |-> !o_odt_en)
    else $error("termination on in self-refresh");
  a_dll_bit_track: assert property (is_mrs && pin_reg.ba == 3'h1
    |=> o_dll_off == $past(pin_reg.addr[MR1_DLL_BIT]))
    else $error("DLL bit not taken");
  a_dll_off_lat: assert property (dll_off_reg && burst_go && is_rd && al_val == 5'h00
    |-> ##5 o_rd_start)
    else $error("DLL-off latency wrong");
  a_idle_meaning: assert property (o_idle |-> state_reg == ST_IDLE && !burst_busy)
    else $error("idle with work pending");

  c_sref_cycle: cover property (state_reg == ST_SREF ##[1:20] state_reg == ST_IDLE);
  c_apd_entry: cover property (state_reg == ST_ACT ##1 state_reg == ST_APD);
  c_dll_off_read: cover property (dll_off_reg && burst_go && is_rd);
  c_ppd_exit: cover property (state_reg == ST_PPD ##1 state_reg == ST_IDLE);

endmodule

// ==== tb/ddr3_ctrl_model.sv ====
// Controller-side model that drives the device command and clock-enable pins
module ddr3_ctrl_model
  import ddr3_pwr_pkg::*;
(
  // Clock
  input  wire logic i_sys_clk,
  // Device pins
  output pin_type   o_pins
);
  logic odt_lvl;
  logic in_sref;
  int since_cke;
  pin_type last;

  initial begin
    o_pins = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, odt: 1'b0,
               ba: 3'h0, addr: 16'h0000};
    last = o_pins;
    odt_lvl = 1'b0;
    in_sref = 1'b0;
    since_cke = 8;
  end

  function automatic pin_type mk(logic cke, logic [2:0] code, logic [2:0] ba,
                                 logic [15:0] addr, logic desel);
    pin_type p;
    p.cke = cke;
    p.cs_n = desel;
    p.odt = odt_lvl;
    // An unselected bus shows the inverse of its last value, never a held command
    {p.ras_n, p.cas_n, p.we_n} = desel ? ~{last.ras_n, last.cas_n, last.we_n} : code;
    p.ba = desel ? ~last.ba : ba;
    p.addr = desel ? ~last.addr : addr;
    return p;
  endfunction

  task automatic drive(input pin_type p);
    @(posedge i_sys_clk);
    since_cke = (p.cke !== last.cke) ? 1 : since_cke + 1;
    last = p;
    o_pins <= p;
  endtask

  task automatic nops(input int n);
    repeat (n) drive(mk(last.cke, CMD_NOP, 3'h0, 16'h0000, 1'b0));
  endtask

  task automatic cmd(input logic cke, input logic [2:0] code, input logic [2:0] ba,
                     input logic [15:0] addr, input logic desel);
    logic rise;
    rise = cke && !last.cke;
    while (cke !== last.cke && since_cke < CKE_MIN_CYC) nops(1);
    drive(mk(cke, code, ba, addr, desel));
    if (!desel && cke && code == CMD_MRS) nops(MOD_CYC);
    if (rise && in_sref) nops(XSDLL_CYC);
    in_sref = rise ? 1'b0 : (in_sref | (!cke && !desel && code == CMD_REF));
  endtask
endmodule

// ==== tb/ddr3_power_state_and_dll_mode_tb.sv ====
// Self-checking bench for the DDR3 power-state and DLL-mode block
module ddr3_power_state_and_dll_mode_tb import ddr3_pwr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk, i_rst, i_reset_n, i_reg_wr, i_reg_rd;
  pin_type pins;
  logic [3:0] i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, rd;
  pwr_state_type o_power_state;
  logic o_idle, o_dll_off, o_burst_busy, o_rd_start, o_wr_start, o_odt_en;
  logic o_self_refresh, o_illegal;
  logic [2:0] cl_f, bk;
  int n_mismatch, cmp_count, lat, busy, pulses;

  ddr3_ctrl_model ctl_u (.i_sys_clk(i_sys_clk), .o_pins(pins));
  ddr3_pwr_ctrl dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reset_n(i_reset_n),
    .i_pins(pins), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_power_state(o_power_state),
    .o_idle(o_idle), .o_dll_off(o_dll_off), .o_burst_busy(o_burst_busy),
    .o_rd_start(o_rd_start), .o_wr_start(o_wr_start), .o_odt_en(o_odt_en),
    .o_self_refresh(o_self_refresh), .o_illegal(o_illegal));

  // Clock well below any DLL-off ceiling
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_cnt(input string name, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask

  task automatic wait_st(input pwr_state_type exp);
    for (int k = 0; k < 8 && o_power_state !== exp; k++) begin
      @(posedge i_sys_clk);
      #1;
    end
    chk_val("power_state", 32'(exp), 32'(o_power_state));
  endtask

  task automatic count_sr(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge i_sys_clk);
      #1 if (o_self_refresh === 1'b1) c++;
    end
  endtask

  // Latency to the start pulse and length of the busy window, with NOPs behind
  task automatic measure(input logic is_wr, output int l, output int b);
    l = 0;
    b = 0;
    fork
      ctl_u.nops(14);
      for (int k = 1; k <= 14; k++) begin
        @(posedge i_sys_clk);
        #1 if ((is_wr ? o_wr_start : o_rd_start) === 1'b1 && l == 0) l = k;
        if (o_burst_busy === 1'b1) b++;
      end
    join
  endtask

  task automatic rw_pair(input int rl, input int wl);
    ctl_u.cmd(1'b1, CMD_ACT, bk, 16'($urandom), 1'b0);
    ctl_u.nops(2);
    ctl_u.cmd(1'b1, CMD_RD, bk, 16'h0000, 1'b0);
    measure(1'b0, lat, busy);
    chk_cnt("read_latency", 2 + rl, lat);
    chk_cnt("read_burst", int'(BL8_CLK), busy);
    ctl_u.cmd(1'b1, CMD_WR, bk, 16'h0000, 1'b0);
    measure(1'b1, lat, busy);
    chk_cnt("write_latency", 2 + wl, lat);
    ctl_u.cmd(1'b1, CMD_PRE, 3'h0, 16'h0400, 1'b0);
    wait_st(ST_IDLE);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    {i_rst, i_reset_n, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {2'b11, 38'h0};
    n_mismatch = 0;
    cmp_count = 0;
    void'($urandom(53739));
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1 chk_val("power_state", 32'(ST_IDLE), 32'(o_power_state));
    reg_rd(REG_CTRL, rd);
    chk_val("ctrl", 32'(CTRL_RESET), rd);
    reg_rd(4'h7 + 4'($urandom_range(8, 0)), rd);
    chk_val("unmapped", 32'h0000_0000, rd);
    ctl_u.nops(4);
    // Precharge power-down, nothing refreshed inside
    ctl_u.cmd(1'b0, CMD_NOP, 3'h0, 16'h0000, 1'($urandom));
    wait_st(ST_PPD);
    chk_val("idle", 32'h0, 32'(o_idle));
    count_sr(250, pulses);
    chk_cnt("refresh_in_pd", 0, pulses);
    ctl_u.cmd(1'b1, CMD_NOP, 3'h0, 16'h0000, 1'($urandom));
    wait_st(ST_IDLE);
    ctl_u.nops(4);
    chk_val("idle", 32'h1, 32'(o_idle));
    // Exit attempt carrying a real command is refused
    ctl_u.cmd(1'b0, CMD_NOP, 3'h0, 16'h0000, 1'b0);
    wait_st(ST_PPD);
    ctl_u.cmd(1'b1, CMD_ACT, 3'h0, 16'h0000, 1'b0);
    ctl_u.nops(3);
    chk_val("power_state", 32'(ST_PPD), 32'(o_power_state));
    reg_rd(REG_STATUS, rd);
    chk_val("status_illegal", 32'h1, 32'(rd[7]));
    ctl_u.cmd(1'b0, CMD_NOP, 3'h0, 16'h0000, 1'b0);
    ctl_u.cmd(1'b1, CMD_NOP, 3'h0, 16'h0000, 1'b1);
    wait_st(ST_IDLE);
    reg_wr(REG_CTRL, {30'($urandom), 2'b11});
    ctl_u.nops(2);
    chk_val("illegal", 32'h0, 32'(o_illegal));
    // Active power-down with a bank open
    bk = 3'($urandom);
    ctl_u.cmd(1'b1, CMD_ACT, bk, 16'($urandom), 1'b0);
    wait_st(ST_ACT);
    ctl_u.cmd(1'b0, CMD_NOP, 3'h0, 16'h0000, 1'b1);
    wait_st(ST_APD);
    ctl_u.cmd(1'b1, CMD_NOP, 3'h0, 16'h0000, 1'b0);
    wait_st(ST_ACT);
    ctl_u.cmd(1'b1, CMD_PRE, 3'h0, 16'h0400, 1'b0);
    wait_st(ST_IDLE);
    // Latencies with the DLL on, then off
    cl_f = 3'($urandom_range(3, 0));
    ctl_u.cmd(1'b1, CMD_MRS, 3'h0, {9'h000, cl_f, 4'h0}, 1'b0);
    rw_pair(int'(CL_BASE) + int'(cl_f), int'(CWL_BASE));
    ctl_u.cmd(1'b1, CMD_MRS, 3'h1, 16'h0001, 1'b0);
    chk_val("dll_off", 32'h1, 32'(o_dll_off));
    rw_pair(int'(DLL_OFF_CL) - 1, int'(DLL_OFF_CWL));
    // Self-refresh with termination requested until the exit
    ctl_u.odt_lvl = 1'b1;
    ctl_u.nops(4);
    #1 chk_val("odt_en", 32'h1, 32'(o_odt_en));
    ctl_u.cmd(1'b0, CMD_REF, 3'h0, 16'h0000, 1'b0);
    wait_st(ST_SREF);
    chk_val("odt_en", 32'h0, 32'(o_odt_en));
    count_sr(SREF_CYC + 5, pulses);
    chk_cnt("refresh_in_sr", 1, int'(pulses > 0));
    ctl_u.odt_lvl = 1'b0;
    ctl_u.cmd(1'b1, CMD_NOP, 3'h0, 16'h0000, 1'($urandom));
    wait_st(ST_IDLE);
    chk_val("illegal", 32'h0, 32'(o_illegal));
    ctl_u.cmd(1'b1, CMD_MRS, 3'h1, 16'h0000, 1'b0);
    chk_val("dll_off", 32'h0, 32'(o_dll_off));
    // Reset pin in mid-run
    ctl_u.cmd(1'b1, CMD_ACT, bk, 16'h0000, 1'b0);
    wait_st(ST_ACT);
    @(posedge i_sys_clk);
    i_reset_n <= 1'b0;
    ctl_u.nops(1);
    #1 chk_val("power_state", 32'(ST_IDLE), 32'(o_power_state));
    @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    ctl_u.nops(4);
    #1 chk_val("power_state", 32'(ST_IDLE), 32'(o_power_state));
    reg_rd(REG_STATUS, rd);
    chk_val("status_banks", 32'h0, {24'h0, rd[23:16]});
    chk_val("status_illegal", 32'h0, 32'(rd[7]));
    complete_run();
  end
endmodule
